// [hdl/i2c_master_regs.vh]
// register map, field positions, reset values and timing counts of the i2c master data block
`ifndef I2C_MASTER_REGS_VH
`define I2C_MASTER_REGS_VH

`define ADDR_RECEIVE_DATA      32'h40003408
`define ADDR_TRANSMIT_DATA     32'h4000340c
`define ADDR_RECEIVE_COUNT     32'h40003410
`define ADDR_CURRENT_COUNT     32'h40003414
`define ADDR_FIRST_ADDRESS     32'h40003418
`define ADDR_SECOND_ADDRESS    32'h4000341c
`define ADDR_CONTROL           32'h40003440
`define ADDR_STATUS            32'h40003444
`define ADDR_IRQ_MASK          32'h40003448

`define REG_RESET              16'h0000
`define CNT_LONG_READ_BIT      8
`define CTRL_GO_BIT            0
`define CTRL_TEN_BIT           1
`define CTRL_TEN_READ_BIT      2
`define ST_RX_REQ              3
`define ST_NACK                4
`define ST_BUSY                6
`define ST_DONE                8
`define ST_RX_OVF              9
`define IRQ_MASK_BITS          16'h0318
`define TEN_BIT_PREFIX         5'h1e
`define TXLVL_EMPTY            2'h0
`define TXLVL_ONE              2'h2
`define TXLVL_FULL             2'h3

`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`define CMD_START              2'h0
`define CMD_WRITE              2'h1
`define CMD_READ               2'h2
`define CMD_STOP               2'h3

`define CLK_PERIOD_NS          4
`define SCL_PERIOD_NS          2500
`define QUARTER_CYCLES         ((`SCL_PERIOD_NS) / (4 * `CLK_PERIOD_NS))

`endif

// [hdl/i2c_bit_engine.v]
// bit-level i2c engine: start, stop, and nine-bit byte transfers on open-drain pins
`timescale 1ns/10ps
`include "i2c_master_regs.vh"
module i2c_bit_engine (
  input  wire       aclk,      // peripheral clock
  input  wire       aresetn,   // synchronous reset, active low
  input  wire       cmd_valid, // one-cycle command strobe, taken when idle
  input  wire [1:0] cmd,       // start, write, read or stop
  input  wire [7:0] tx_byte,   // byte to send on write
  input  wire       ack_send,  // drive ack after a read byte
  output reg        busy,      // command in progress
  output reg        done,      // one-cycle pulse at command end
  output wire [7:0] rx_byte,   // byte sampled by the last read
  output wire       nack,      // acknowledge bit sampled after a write
  input  wire       scl_in,    // clock pin level
  input  wire       sda_in,    // data pin level
  output reg        scl_out,   // clock pin value when enabled
  output reg        scl_oe,    // high while pulling the clock low
  output reg        sda_out,   // data pin value when enabled
  output reg        sda_oe     // high while pulling data low
);
  localparam integer QUARTER_INT  = `QUARTER_CYCLES - 1;
  localparam [9:0]   QUARTER_LAST = QUARTER_INT[9:0];

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg       scl_level;
  reg       sda_level;
  reg [9:0] div;
  reg [1:0] phase;
  reg [1:0] op;
  reg [8:0] shift;
  reg [3:0] nbit;

  assign rx_byte = shift[8:1];
  assign nack    = shift[0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_sync  <= 3'h7;
      sda_sync  <= 3'h7;
      scl_level <= 1'b1;
      sda_level <= 1'b1;
      busy      <= 1'b0;
      done      <= 1'b0;
      div       <= 10'h000;
      phase     <= 2'h0;
      op        <= `CMD_START;
      shift     <= 9'h1ff;
      nbit      <= 4'h0;
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else
    begin
      done     <= 1'b0;
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2])
        scl_level <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_level <= sda_sync[2];
      if (!busy)
      begin
        if (cmd_valid)
        begin
          busy  <= 1'b1;
          op    <= cmd;
          phase <= 2'h0;
          div   <= 10'h000;
          nbit  <= 4'h0;
          shift <= (cmd == `CMD_READ) ? {8'hff, ~ack_send} : {tx_byte, 1'b1};
          if (cmd == `CMD_START)
            sda_oe <= 1'b0;
          else if (cmd == `CMD_STOP)
            sda_oe <= 1'b1;
          else if (cmd == `CMD_READ)
            sda_oe <= 1'b0;
          else
            sda_oe <= ~tx_byte[7];
        end
      end
      else if (div != QUARTER_LAST)
        div <= div + 10'h001;
      // a slave stretching the clock holds us at the end of the first high quarter, before sampling
      else if (!(phase == 2'h1 && !scl_level))
      begin
        div   <= 10'h000;
        phase <= phase + 2'h1;
        case (phase)
          2'h0: scl_oe <= 1'b0;
          2'h1:
          begin
            if (op == `CMD_START)
              sda_oe <= 1'b1;
            else if (op == `CMD_STOP)
              sda_oe <= 1'b0;
            else
              shift <= {shift[7:0], sda_level};
          end
          2'h2:
          begin
            if (op != `CMD_STOP)
              scl_oe <= 1'b1;
          end
          default:
          begin
            if (op == `CMD_START || op == `CMD_STOP || nbit == 4'h8)
            begin
              busy <= 1'b0;
              done <= 1'b1;
            end
            else
            begin
              nbit   <= nbit + 4'h1;
              sda_oe <= ~shift[8];
            end
          end
        endcase
      end
    end
  end
endmodule // i2c_bit_engine

// [hdl/i2c_master_data_count_address.v]
// i2c master data path: fifos, receive counts, address bytes, axi4-lite register slave
//
// Overview of operation
// - reading receive data returns oldest byte of a two-entry fifo in bits 7:0
// - a transmit data write pushes one byte into the two-entry transmit fifo unless it is full
// - reading transmit data returns the data byte last popped from the transmit fifo onto the bus
// - receive count holds bytes wanted minus one; zero means one byte, up to 256
// - long-read bit 8 keeps the master receiving past the programmed count
// - an 8-bit read-only count of received bytes wraps to zero after 256
// - 7-bit mode: first address byte holds address in 7:1, direction in bit 0
// - 10-bit mode: first byte holds 11110, two address msbs, and zero
// - every 16-bit register but receive data resets to zero; upper byte reads zero except receive count, status, irq mask
// - 10-bit mode: second address byte with low address bits follows the first
// - receive overflow flag sets when a byte arrives at a full fifo; read clears
// - receive request bit is high while the receive fifo holds data; may interrupt
// - transmit fifo level reads 00 empty, 10 one byte, 11 full
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`include "i2c_master_regs.vh"
module i2c_master_data_count_address (
  input  wire        aclk,    // peripheral clock, 250 MHz
  input  wire        aresetn, // synchronous reset, active low
  input  wire [31:0] awaddr,  // write address
  input  wire        awvalid, // write address valid
  output reg         awready, // write address ready
  input  wire [31:0] wdata,   // write data
  input  wire [3:0]  wstrb,   // write byte strobes
  input  wire        wvalid,  // write data valid
  output reg         wready,  // write data ready
  output reg  [1:0]  bresp,   // write response
  output reg         bvalid,  // write response valid
  input  wire        bready,  // write response ready
  input  wire [31:0] araddr,  // read address
  input  wire        arvalid, // read address valid
  output reg         arready, // read address ready
  output reg  [31:0] rdata,   // read data
  output reg  [1:0]  rresp,   // read response
  output reg         rvalid,  // read data valid
  input  wire        rready,  // read data ready
  output reg         irq,     // level interrupt
  input  wire        scl_in,  // clock pin level
  input  wire        sda_in,  // data pin level
  output wire        scl_out, // clock pin value, always low
  output wire        scl_oe,  // clock pin pull-down enable
  output wire        sda_out, // data pin value, always low
  output wire        sda_oe   // data pin pull-down enable
);
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_START  = 4'h1;
  localparam [3:0] S_ADDR0  = 4'h2;
  localparam [3:0] S_ADDR1  = 4'h3;
  localparam [3:0] S_RSTART = 4'h4;
  localparam [3:0] S_ADDR0R = 4'h5;
  localparam [3:0] S_WDATA  = 4'h6;
  localparam [3:0] S_RDATA  = 4'h7;
  localparam [3:0] S_STOP   = 4'h8;

  reg        aw_full;
  reg        w_full;
  reg        ar_full;
  reg [31:0] waddr;
  reg [31:0] wdat;
  reg [3:0]  wstb;
  reg [31:0] raddr;
  reg [7:0]  receive_count_reg;
  reg        long_read;
  reg [7:0]  current_count_reg;
  reg [7:0]  address_byte_zero;
  reg [7:0]  address_byte_one;
  reg        ten_bit;
  reg        ten_read;
  reg [15:0] irq_mask;
  reg        nack_flag;
  reg        done_flag;
  reg        receive_overflow_flag;
  reg [7:0]  transmit_byte_field;
  reg [7:0]  tx_mem [0:1];
  reg        tx_rd;
  reg        tx_wr;
  reg [1:0]  tx_cnt;
  reg [7:0]  rx_mem [0:1];
  reg        rx_rd;
  reg        rx_wr;
  reg [1:0]  rx_cnt;
  reg [3:0]  st;
  reg        rd_last;
  reg        eng_valid;
  reg [1:0]  eng_cmd;
  reg [7:0]  eng_byte;
  reg        eng_ack;
  reg [3:0]  next_st;
  reg        issue;
  reg [1:0]  next_cmd;
  reg [7:0]  next_byte;
  reg        next_ack;
  reg        tx_pop;
  reg        ev_nack;
  reg        ev_done;
  reg [1:0]  transmit_fifo_level;
  reg [15:0] status_word;
  reg [15:0] read_value;
  reg        read_hit;
  reg        write_hit;

  wire       eng_done;
  wire [7:0] eng_rx;
  wire       eng_nack;

  wire wr_en   = aw_full && w_full && !bvalid;
  wire rd_en   = ar_full && !rvalid;
  wire wr_low  = wr_en && wstb[0];
  wire wr_high = wr_en && wstb[1];
  wire go      = wr_low && waddr == `ADDR_CONTROL && wdat[`CTRL_GO_BIT] && st == S_IDLE;
  wire is_read = ten_bit ? ten_read : address_byte_zero[0];
  wire tx_push = wr_low && waddr == `ADDR_TRANSMIT_DATA && tx_cnt != 2'h2;
  wire rx_pop  = rd_en && raddr == `ADDR_RECEIVE_DATA && rx_cnt != 2'h0;
  wire rx_in   = eng_done && st == S_RDATA;
  wire rx_push = rx_in && rx_cnt != 2'h2;
  wire rx_ovf  = rx_in && rx_cnt == 2'h2;
  wire st_clr  = rd_en && raddr == `ADDR_STATUS;
  wire [15:0] mask_in = wdat[15:0] & `IRQ_MASK_BITS;
  // the byte just received already counts when the next read is decided
  wire [7:0] count_after = (st == S_RDATA) ? current_count_reg + 8'h01 : current_count_reg;
  wire last_byte = !long_read && count_after == receive_count_reg;

  i2c_bit_engine u_engine (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cmd_valid (eng_valid),
    .cmd       (eng_cmd),
    .tx_byte   (eng_byte),
    .ack_send  (eng_ack),
    .busy      (),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .nack      (eng_nack),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_out   (scl_out),
    .scl_oe    (scl_oe),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe)
  );

  always @*
  begin
    next_st   = st;
    issue     = 1'b0;
    next_cmd  = `CMD_STOP;
    next_byte = 8'h00;
    next_ack  = 1'b0;
    tx_pop    = 1'b0;
    ev_nack   = 1'b0;
    ev_done   = 1'b0;
    case (st)
      S_IDLE:
      begin
        if (go)
        begin
          next_st  = S_START;
          issue    = 1'b1;
          next_cmd = `CMD_START;
        end
      end
      S_STOP:
      begin
        if (eng_done)
        begin
          next_st = S_IDLE;
          ev_done = 1'b1;
        end
      end
      default:
      begin
        if (eng_done)
        begin
          issue    = 1'b1;
          next_cmd = `CMD_WRITE;
          if (st == S_START)
          begin
            next_st   = S_ADDR0;
            next_byte = ten_bit ? {address_byte_zero[7:1], 1'b0} : address_byte_zero;
          end
          else if (st == S_RSTART)
          begin
            next_st   = S_ADDR0R;
            next_byte = {address_byte_zero[7:1], 1'b1};
          end
          else if (st != S_RDATA && eng_nack)
          begin
            next_st  = S_STOP;
            next_cmd = `CMD_STOP;
            ev_nack  = 1'b1;
          end
          else if (st == S_ADDR0 && ten_bit)
          begin
            next_st   = S_ADDR1;
            next_byte = address_byte_one;
          end
          else if (st == S_ADDR1 && is_read)
          begin
            next_st  = S_RSTART;
            next_cmd = `CMD_START;
          end
          else if (st == S_RDATA && rd_last)
          begin
            next_st  = S_STOP;
            next_cmd = `CMD_STOP;
          end
          else if (is_read)
          begin
            next_st  = S_RDATA;
            next_cmd = `CMD_READ;
            next_ack = !last_byte;
          end
          else if (tx_cnt != 2'h0)
          begin
            next_st   = S_WDATA;
            next_byte = tx_mem[tx_rd];
            tx_pop    = 1'b1;
          end
          else
          begin
            next_st  = S_STOP;
            next_cmd = `CMD_STOP;
          end
        end
      end
    endcase
  end

  always @*
  begin
    case (tx_cnt)
      2'h0:    transmit_fifo_level = `TXLVL_EMPTY;
      2'h1:    transmit_fifo_level = `TXLVL_ONE;
      default: transmit_fifo_level = `TXLVL_FULL;
    endcase
    status_word                 = `REG_RESET;
    status_word[1:0]            = transmit_fifo_level;
    status_word[`ST_RX_REQ]     = rx_cnt != 2'h0;
    status_word[`ST_NACK]       = nack_flag;
    status_word[`ST_BUSY]       = st != S_IDLE;
    status_word[`ST_DONE]       = done_flag;
    status_word[`ST_RX_OVF]     = receive_overflow_flag;
    read_hit                    = 1'b1;
    case (raddr)
      `ADDR_RECEIVE_DATA:   read_value = {8'h00, rx_mem[rx_rd]};
      `ADDR_TRANSMIT_DATA:  read_value = {8'h00, transmit_byte_field};
      `ADDR_RECEIVE_COUNT:  read_value = {7'h00, long_read, receive_count_reg};
      `ADDR_CURRENT_COUNT:  read_value = {8'h00, current_count_reg};
      `ADDR_FIRST_ADDRESS:  read_value = {8'h00, address_byte_zero};
      `ADDR_SECOND_ADDRESS: read_value = {8'h00, address_byte_one};
      `ADDR_CONTROL:        read_value = {13'h0000, ten_read, ten_bit, st != S_IDLE};
      `ADDR_STATUS:         read_value = status_word;
      `ADDR_IRQ_MASK:       read_value = irq_mask;
      default:
      begin
        read_value = `REG_RESET;
        read_hit   = 1'b0;
      end
    endcase
    case (waddr)
      `ADDR_RECEIVE_DATA, `ADDR_TRANSMIT_DATA, `ADDR_RECEIVE_COUNT, `ADDR_CURRENT_COUNT,
      `ADDR_FIRST_ADDRESS, `ADDR_SECOND_ADDRESS, `ADDR_CONTROL, `ADDR_STATUS,
      `ADDR_IRQ_MASK: write_hit = 1'b1;
      default:        write_hit = 1'b0;
    endcase
  end

  // axi4-lite slave: one write and one read in flight, address and data in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      ar_full <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `RESP_OKAY;
      rdata   <= 32'h00000000;
      waddr   <= 32'h00000000;
      wdat    <= 32'h00000000;
      wstb    <= 4'h0;
      raddr   <= 32'h00000000;
    end
    else
    begin
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      else
      begin
        if (awvalid && awready)
        begin
          aw_full <= 1'b1;
          awready <= 1'b0;
          waddr   <= awaddr;
        end
        else if (!aw_full && !bvalid)
          awready <= 1'b1;
        if (wvalid && wready)
        begin
          w_full <= 1'b1;
          wready <= 1'b0;
          wdat   <= wdata;
          wstb   <= wstrb;
        end
        else if (!w_full && !bvalid)
          wready <= 1'b1;
        if (wr_en)
        begin
          bvalid <= 1'b1;
          bresp  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
      else if (arvalid && arready)
      begin
        ar_full <= 1'b1;
        arready <= 1'b0;
        raddr   <= araddr;
      end
      else if (rd_en)
      begin
        ar_full <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {16'h0000, read_value};
        rresp   <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (!ar_full && !rvalid)
        arready <= 1'b1;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      receive_count_reg     <= 8'h00;
      long_read             <= 1'b0;
      current_count_reg     <= 8'h00;
      address_byte_zero     <= 8'h00;
      address_byte_one      <= 8'h00;
      ten_bit               <= 1'b0;
      ten_read              <= 1'b0;
      irq_mask              <= `REG_RESET;
      nack_flag             <= 1'b0;
      done_flag             <= 1'b0;
      receive_overflow_flag <= 1'b0;
      transmit_byte_field   <= 8'h00;
      tx_rd                 <= 1'b0;
      tx_wr                 <= 1'b0;
      tx_cnt                <= 2'h0;
      rx_rd                 <= 1'b0;
      rx_wr                 <= 1'b0;
      rx_cnt                <= 2'h0;
      st                    <= S_IDLE;
      rd_last               <= 1'b0;
      eng_valid             <= 1'b0;
      eng_cmd               <= `CMD_START;
      eng_byte              <= 8'h00;
      eng_ack               <= 1'b0;
      irq                   <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      eng_valid <= issue;
      eng_cmd   <= next_cmd;
      eng_byte  <= next_byte;
      eng_ack   <= next_ack;
      if (issue && next_cmd == `CMD_READ)
        rd_last <= !next_ack;
      if (tx_pop)
        transmit_byte_field <= next_byte;
      if (wr_low)
      begin
        if (waddr == `ADDR_RECEIVE_COUNT)
          receive_count_reg <= wdat[7:0];
        if (waddr == `ADDR_FIRST_ADDRESS)
          address_byte_zero <= wdat[7:0];
        if (waddr == `ADDR_SECOND_ADDRESS)
          address_byte_one <= wdat[7:0];
        if (waddr == `ADDR_IRQ_MASK)
          irq_mask[7:0] <= mask_in[7:0];
        if (waddr == `ADDR_CONTROL)
        begin
          ten_bit  <= wdat[`CTRL_TEN_BIT];
          ten_read <= wdat[`CTRL_TEN_READ_BIT];
        end
      end
      if (wr_high && waddr == `ADDR_RECEIVE_COUNT)
        long_read <= wdat[`CNT_LONG_READ_BIT];
      if (wr_high && waddr == `ADDR_IRQ_MASK)
        irq_mask[15:8] <= mask_in[15:8];
      // wraps naturally, so a 256-byte read leaves zero behind
      if (go)
        current_count_reg <= 8'h00;
      else if (rx_in)
        current_count_reg <= current_count_reg + 8'h01;
      if (tx_push)
      begin
        tx_mem[tx_wr] <= wdat[7:0];
        tx_wr         <= ~tx_wr;
      end
      if (tx_pop)
        tx_rd <= ~tx_rd;
      tx_cnt <= tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
      // a byte landing on a full fifo is dropped; the flag tells software
      if (rx_push)
      begin
        rx_mem[rx_wr] <= eng_rx;
        rx_wr         <= ~rx_wr;
      end
      if (rx_pop)
        rx_rd <= ~rx_rd;
      rx_cnt <= rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
      // an event in the clearing cycle survives the read
      nack_flag             <= (nack_flag & ~st_clr) | ev_nack;
      done_flag             <= (done_flag & ~st_clr) | ev_done;
      receive_overflow_flag <= (receive_overflow_flag & ~st_clr) | rx_ovf;
      irq                   <= |(status_word & irq_mask);
    end
  end
endmodule // i2c_master_data_count_address

// [dv/i2c_master_checker_asserts.sv]
// concurrent checks on the register bus and pin enables of the i2c master data block
`timescale 1ns/10ps
`include "i2c_master_regs.vh"
module i2c_master_checker (
  input wire        aclk,    // peripheral clock
  input wire        aresetn, // synchronous reset, active low
  input wire        awvalid, awready, wvalid, wready, bvalid, bready, // write handshakes
  input wire        arvalid, arready, rvalid, rready, irq,            // read handshakes, irq
  input wire        scl_oe, sda_oe, // pin pull-down enables
  input wire [31:0] awaddr, rdata,  // write address, read data
  input wire [1:0]  bresp, rresp    // responses
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // decoded map: data, count and address words, then control, status and mask
  wire aw_map = (awaddr[31:5] == 27'h20001a0 && awaddr[4:3] != 2'h0 ||
                 awaddr[31:4] == 28'h4000344 && awaddr[3:2] != 2'h3) && awaddr[1:0] == 2'h0;
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  b_after_take_a: assert property (wr_take |-> ##2 bvalid)
    else $error("write response late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  block_ready_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken before response");
  r_latency_a: assert property (rd_take |-> ##[1:2] rvalid)
    else $error("read data late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  unmapped_err_a: assert property (wr_take and !aw_map |-> ##2 bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
  upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  reset_quiet_a: assert property ($rose(aresetn) |->
    !bvalid && !rvalid && !irq && !scl_oe && !sda_oe)
    else $error("outputs active out of reset");
endmodule // i2c_master_checker
bind i2c_master_data_count_address i2c_master_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .irq(irq), .scl_oe(scl_oe), .sda_oe(sda_oe), .awaddr(awaddr), .rdata(rdata),
  .bresp(bresp), .rresp(rresp));

// [dv/i2c_slave_model.sv]
// behavioural i2c slave: acks any address, answers reads with a counting byte pattern
`timescale 1ns/10ps
module i2c_slave_model (
  input  wire       scl,      // clock wire level
  input  wire       sda,      // data wire level
  output reg        sda_low,  // high while pulling data low
  output reg  [7:0] addr_seen // first byte after the last start
);
  reg [7:0] b;
  reg [7:0] d;
  reg       ack;
  integer   i;
  initial
  begin
    sda_low = 1'b0;
    addr_seen = 8'h0;
    forever
    begin
      @(negedge sda iff scl === 1'b1);
      for (i = 0; i < 8; i = i + 1)
        @(posedge scl) b = {b[6:0], sda};
      addr_seen = b;
      d = 8'ha5;
      @(negedge scl) #1 sda_low = 1'b1;
      // direction bit picks whether we keep driving after the address ack
      @(negedge scl) #1 sda_low = b[0] & ~d[7];
      ack = b[0];
      while (ack)
      begin
        for (i = 6; i >= 0; i = i - 1)
          @(negedge scl) #1 sda_low = ~d[i];
        @(negedge scl) #1 sda_low = 1'b0;
        @(posedge scl) ack = ~sda;
        d = d + 8'h11;
        @(negedge scl) #1 sda_low = ack & ~d[7];
      end
    end
  end
endmodule // i2c_slave_model

// [dv/tb.sv]
// self-checking bench: register map, fifo levels, counts and a three-byte read on the wire
`timescale 1ns/10ps
`include "i2c_master_regs.vh"
module tb;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [31:0] awaddr, wdata, araddr, rnd;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid, irq;
  wire        scl_out, scl_oe, sda_out, sda_oe, sda_low;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [7:0]  addr_seen;
  wire        scl = !scl_oe;
  wire        sda = !(sda_oe || sda_low);
  integer     n_errors, checked, i;
  reg  [15:0] got, adr;
  reg  [1:0]  resp;
  i2c_master_data_count_address u_i2c_master_data_count_address (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .scl_in(scl), .sda_in(sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_slave_model u_i2c_slave_model (.scl(scl), .sda(sda), .sda_low(sda_low),
    .addr_seen(addr_seen));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function [1:0] txlvl(input integer n);
    txlvl = n == 0 ? `TXLVL_EMPTY : n == 1 ? `TXLVL_ONE : `TXLVL_FULL;
  endfunction
  function [7:0] sbyte(input integer k);
    sbyte = 8'ha5 + 8'h11 * k;
  endfunction
  task chk(input [17:0] g, input [17:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [31:0] a, input [15:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
        begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
        begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
      join
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [31:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      got = rdata[15:0];
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
  task rc(input [31:0] a, input [15:0] e);
    begin
      rd(a);
      chk(got, e);
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d in %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    // the read frame takes about 24k cycles at 400 kHz, so allow some margin
    repeat (40000) @(posedge aclk);
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial
  begin
    n_errors = 0;
    checked = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    rnd = $urandom(32'h96b2);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 9; i = i + 1)
      rc(i < 6 ? `ADDR_RECEIVE_DATA + 4 * i : `ADDR_CONTROL + 4 * (i - 6), 16'h0);
    wr(32'h40003420, 16'h1234);
    chk(resp, `RESP_SLVERR);
    rd(32'h40003450);
    chk({resp, got}, {`RESP_SLVERR, 16'h0});
    for (i = 1; i < 4; i = i + 1)
    begin
      rnd = $urandom;
      wr(`ADDR_TRANSMIT_DATA, {8'h0, rnd[7:0]});
      rc(`ADDR_STATUS, txlvl(i));
    end
    rnd = $urandom;
    adr = {8'h0, rnd[6:0], 1'b1};
    wr(`ADDR_FIRST_ADDRESS, adr);
    rc(`ADDR_FIRST_ADDRESS, adr);
    wr(`ADDR_RECEIVE_COUNT, 16'h0100);
    rc(`ADDR_RECEIVE_COUNT, 16'h0100);
    wr(`ADDR_RECEIVE_COUNT, 16'h0002);
    rc(`ADDR_RECEIVE_COUNT, 16'h0002);
    wr(`ADDR_IRQ_MASK, 16'h0008);
    chk(irq, 1'b0);
    wr(`ADDR_CONTROL, 16'h0001);
    i = 0;
    do rd(`ADDR_CONTROL); while (got[0] !== 1'b1 && (i++) < 20);
    do rd(`ADDR_CONTROL); while (got[0] !== 1'b0 && (i++) < 30000);
    chk(addr_seen, adr);
    rc(`ADDR_CURRENT_COUNT, 16'h0003);
    wr(`ADDR_CURRENT_COUNT, 16'h0055);
    rc(`ADDR_CURRENT_COUNT, 16'h0003);
    chk(irq, 1'b1);
    rc(`ADDR_STATUS, {6'h0, 2'h3, 4'h0, 2'h2, txlvl(3)});
    rc(`ADDR_RECEIVE_DATA, sbyte(0));
    rc(`ADDR_RECEIVE_DATA, sbyte(1));
    rc(`ADDR_STATUS, txlvl(3));
    chk(irq, 1'b0);
    give_verdict;
  end
endmodule // tb
